/* mdsr_bank.sv */
// register bank for range, conversion results, output codes and alarms
// assumes byte accesses from the serial interface decoder on mclk,
// conversion results supplied by the converter on mclk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module mdsr_bank
    import mdsr_pkg::*;
(
    // clocking
    input wire logic mclk,
    input wire logic reset,                     // hardware, software or power-on
    input wire logic clk_en,
    // register access
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // conversion results
    input wire logic conv_done,
    input wire logic [4:0] conv_chan,           // 0..20 channel, 21 temperature
    input wire logic [11:0] conv_result,
    input wire logic [ALARM_COUNT-1:0] out_of_range,
    // alarm configuration
    input wire logic [FILTER_W-1:0] filter_n,
    input wire logic alarm_nonlatching_select,
    input wire logic [ALARM_COUNT-1:0] alarm_source_clear,
    // dac side
    output logic [2:0] group_c_range_select,
    output logic group_c_auto,
    output logic [2:0] group_d_range_select,
    output logic group_d_auto,
    output logic dac_load,
    output logic [3:0] dac_load_chan,
    output logic [11:0] output_code,
    // alarm pin and status
    output logic alarm_output_pin,
    output logic [ALARM_COUNT-1:0] alarm_status
);
    localparam logic [4:0] TEMP_CHAN = 5'h15; // slot after the last channel
    localparam logic [4:0] ALARM_CHAN_BASE = 5'h10; // first channel with an alarm bit

    ////////////////////////////////////////////////////////////////////
    // address decode
    wire hit_range = addr == ADDR_RANGE_CD;
    wire hit_adc = addr >= ADDR_ADC_FIRST && addr <= ADDR_ADC_LAST;
    wire hit_temp_lo = addr == ADDR_TEMP_LOW;
    wire hit_temp_hi = addr == ADDR_TEMP_HIGH;
    wire hit_dac = addr >= ADDR_DAC_FIRST && addr <= ADDR_DAC_LAST;
    wire hit_st0 = addr == ADDR_STATUS0;
    wire hit_st1 = addr == ADDR_STATUS1;
    // offsets into the paired ranges: bit 0 picks the lane, the rest the channel
    wire [7:0] adc_off = addr - ADDR_ADC_FIRST;
    wire [7:0] dac_off = addr - ADDR_DAC_FIRST;
    wire [4:0] adc_chan = adc_off[5:1];
    wire [3:0] dac_chan = dac_off[4:1];
    wire high_lane = addr[0];                   // odd address is high byte
    // strobes count only on enabled edges, so a frozen bank ignores the bus
    wire do_wr = clk_en && wr_en;
    wire do_rd = clk_en && rd_en;

    ////////////////////////////////////////////////////////////////////
    // range register
    logic [7:0] range_cd;                       // group c and d range field
    // reserved bits are dropped on the way in, so they always read back zero
    always_ff @(posedge mclk)
    begin
        if (reset)
            range_cd <= RESET_BYTE;
        else if (do_wr && hit_range)
            range_cd <= wr_data & RANGE_CD_MASK;
    end
    assign group_d_range_select = range_cd[RANGE_D_LSB+:3];
    assign group_c_range_select = range_cd[RANGE_C_LSB+:3];
    assign group_d_auto = !group_d_range_select[2];
    assign group_c_auto = !group_c_range_select[2];

    ////////////////////////////////////////////////////////////////////
    // conversion results
    logic [11:0] adc_res [ADC_CHANNELS];        // unsigned results
    logic [11:0] temp_res;                      // two's complement temperature
    // results are kept as delivered: channels straight binary, temperature
    // two's complement; a channel number past the temperature slot is dropped
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int i = 0; i < ADC_CHANNELS; i++)
                adc_res[i] <= '0;
            temp_res <= '0;
        end
        else if (clk_en && conv_done)
        begin
            if (conv_chan == TEMP_CHAN)
                temp_res <= conv_result;
            else if (conv_chan < TEMP_CHAN)
                adc_res[conv_chan] <= conv_result;
        end
    end
    // guard keeps the array index in range for any address
    wire [11:0] adc_sel = (adc_chan < TEMP_CHAN) ? adc_res[adc_chan] : 12'h000;
    wire [7:0] adc_byte = high_lane ? {4'h0, adc_sel[11:8]} : adc_sel[7:0];

    ////////////////////////////////////////////////////////////////////
    // output code memory, codes passed through unchanged
    // the memory read register follows addr on every enabled edge, so its
    // byte is only valid in the cycle after a read strobe
    logic [7:0] dac_byte;
    mdsr_code_mem u_code_mem
    (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .wr_en(do_wr && hit_dac),
        .wr_chan(dac_chan),
        .wr_high(high_lane),
        .wr_data(wr_data),
        .rd_chan(dac_chan),
        .rd_high(high_lane),
        .rd_data(dac_byte),
        .latch_code(output_code)
    );

    // load strobe follows the written byte by one cycle with the code
    // the latch sees the merged code, so a lone low-byte write updates it too
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            dac_load <= 1'b0;
            dac_load_chan <= '0;
        end
        else if (clk_en)
        begin
            dac_load <= wr_en && hit_dac;
            if (wr_en && hit_dac)
                dac_load_chan <= dac_chan;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarm bits, one per monitored source
    logic [ALARM_COUNT-1:0] cond;               // filtered conditions
    wire [ALARM_COUNT-1:0] bit_is_temp = {{STATUS1_BITS{1'b1}}, {STATUS0_BITS{1'b0}}};
    // a status read clears only the bits of the byte that was read
    wire [ALARM_COUNT-1:0] read_clear =
        {{STATUS1_BITS{do_rd && hit_st1}}, {STATUS0_BITS{do_rd && hit_st0}}};
    wire [ALARM_COUNT-1:0] src_done;
    genvar g;
    generate
        for (g = 0; g < ALARM_COUNT; g++)
        begin : g_alarm
            // channel bits watch the last five channels, temperature bits the sensor;
            // every temperature bit is judged on the one temperature conversion
            assign src_done[g] = conv_done && (bit_is_temp[g] ? conv_chan == TEMP_CHAN
                                 : conv_chan == ALARM_CHAN_BASE + 5'(g));
            mdsr_alarm_bit u_bit
            (
                .mclk(mclk),
                .reset(reset),
                .clk_en(clk_en),
                .conv_done(src_done[g]),
                .out_of_range(out_of_range[g]),
                .filter_n(filter_n),
                .nonlatching(alarm_nonlatching_select),
                .status_read(read_clear[g]),
                .alarm(alarm_status[g]),
                .condition(cond[g])
            );
        end
    endgenerate

    // alarm pin is set while any status bit not masked by alarm_source_clear stands
    // pin drops with the status bit, one cycle behind it, so a read releases it
    wire pin_cause = |(alarm_status & ~alarm_source_clear);
    always_ff @(posedge mclk)
    begin
        if (reset)
            alarm_output_pin <= 1'b0;
        else if (clk_en)
            alarm_output_pin <= pin_cause;
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    // status bytes carry the alarm bits low, reserved bits read zero
    wire [7:0] st0 = {3'h0, alarm_status[STATUS0_BITS-1:0]};
    wire [7:0] st1 = {4'h0, alarm_status[ALARM_COUNT-1:STATUS0_BITS]};
    wire [7:0] temp_byte = high_lane ? {4'h0, temp_res[11:8]} : temp_res[7:0];
    // unmapped places fall through to zero
    logic [7:0] reg_byte;
    logic reg_dac;                              // dac data comes a cycle later
    // priority does not matter: the decode hits are exclusive
    always_comb
    begin
        reg_byte = RESET_BYTE;
        if (hit_range)
            reg_byte = range_cd;
        else if (hit_adc)
            reg_byte = adc_byte;
        else if (hit_temp_lo || hit_temp_hi)
            reg_byte = temp_byte;
        else if (hit_st0)
            reg_byte = st0;
        else if (hit_st1)
            reg_byte = st1;
    end

    // read data registered, answer one cycle after request
    logic [7:0] held_byte;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            held_byte <= RESET_BYTE;
            reg_dac <= 1'b0;
            rd_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid <= rd_en;
            reg_dac <= rd_en && hit_dac;
            // an output code byte is copied from the memory register one edge
            // later, so it stands until the next read like any other byte
            if (rd_en)
                held_byte <= reg_byte;
            else if (reg_dac)
                held_byte <= dac_byte;
        end
    end
    // in the answer cycle an output code byte is steered from the memory
    assign rd_data = reg_dac ? dac_byte : held_byte;

    ////////////////////////////////////////////////////////////////////
    // checks
    // a read or an output code byte write taken on this edge
    sequence s_read_taken;
        clk_en && rd_en;
    endsequence
    sequence s_dac_low_write;
        clk_en && wr_en && hit_dac && !high_lane;
    endsequence
    sequence s_dac_high_write;
        clk_en && wr_en && hit_dac && high_lane;
    endsequence

    // range register
    a_range_d_field: assert property (@(posedge mclk) disable iff (reset)
        clk_en && wr_en && hit_range |=> group_d_range_select == $past(wr_data[6:4]))
        else $error("group d range not taken");
    a_range_c_field: assert property (@(posedge mclk) disable iff (reset)
        clk_en && wr_en && hit_range |=> group_c_range_select == $past(wr_data[2:0]))
        else $error("group c range not taken");
    a_range_reserved: assert property (@(posedge mclk) disable iff (reset)
        (range_cd & ~RANGE_CD_MASK) == RESET_BYTE)
        else $error("range reserved bit set");
    a_auto_range: assert property (@(posedge mclk) disable iff (reset)
        group_c_auto == !range_cd[2])
        else $error("auto range decode wrong");
    a_auto_range_d: assert property (@(posedge mclk) disable iff (reset)
        group_d_auto == (group_d_range_select < RNG_NEG10))
        else $error("group d auto decode wrong");

    // read answer and read data
    a_read_answer: assert property (@(posedge mclk) disable iff (reset)
        s_read_taken |=> rd_valid)
        else $error("read not answered");
    a_valid_single: assert property (@(posedge mclk) disable iff (reset)
        clk_en && !rd_en |=> !rd_valid)
        else $error("answer without read");
    a_adc_low_byte: assert property (@(posedge mclk) disable iff (reset)
        clk_en && rd_en && addr == ADDR_ADC_FIRST |=> rd_data == $past(adc_res[0][7:0]))
        else $error("first result low byte wrong");
    a_high_byte_zero: assert property (@(posedge mclk) disable iff (reset)
        clk_en && rd_en && (hit_adc || hit_temp_hi) && high_lane |=> rd_data[7:4] == 4'h0)
        else $error("high byte top bits set");
    a_temp_low_byte: assert property (@(posedge mclk) disable iff (reset)
        clk_en && rd_en && hit_temp_lo |=> rd_data == $past(temp_res[7:0]))
        else $error("temperature low byte wrong");
    a_status_top_zero: assert property (@(posedge mclk) disable iff (reset)
        clk_en && rd_en && (hit_st0 || hit_st1) |=> rd_data[7:5] == 3'h0)
        else $error("status reserved bits set");

    // output codes
    a_dac_low_lane: assert property (@(posedge mclk) disable iff (reset)
        s_dac_low_write |=> output_code[7:0] == $past(wr_data))
        else $error("output code low byte lost");
    a_dac_high_lane: assert property (@(posedge mclk) disable iff (reset)
        s_dac_high_write |=> output_code[11:8] == $past(wr_data[3:0]))
        else $error("output code high bits lost");
    a_dac_load: assert property (@(posedge mclk) disable iff (reset)
        clk_en && wr_en && hit_dac |=> dac_load && dac_load_chan == $past(dac_chan))
        else $error("dac load missing");
    a_load_single: assert property (@(posedge mclk) disable iff (reset)
        clk_en && !(wr_en && hit_dac) |=> !dac_load)
        else $error("dac load without write");
    a_code_stable: assert property (@(posedge mclk) disable iff (reset)
        clk_en && !(wr_en && hit_dac) |=> $stable(output_code))
        else $error("output code moved without write");

    // alarms, filter and clearing checked on the first channel bit, pin and reset on all bits
    a_filter_quiet: assert property (@(posedge mclk) disable iff (reset)
        clk_en && src_done[0] && !out_of_range[0] && !alarm_status[0] |=> !alarm_status[0])
        else $error("alarm set on in-range result");
    a_pin_follows: assert property (@(posedge mclk) disable iff (reset)
        clk_en && pin_cause |=> alarm_output_pin)
        else $error("alarm pin not set");
    a_pin_clear: assert property (@(posedge mclk) disable iff (reset)
        clk_en && !pin_cause |=> !alarm_output_pin)
        else $error("alarm pin stuck");
    a_hold_unread: assert property (@(posedge mclk) disable iff (reset)
        clk_en && alarm_status[0] && !read_clear[0] && !alarm_nonlatching_select
        |=> alarm_status[0])
        else $error("alarm dropped without read");
    a_read_clears: assert property (@(posedge mclk) disable iff (reset)
        clk_en && read_clear[0] && !cond[0] && !src_done[0] |=> !alarm_status[0])
        else $error("alarm not cleared on read");
    a_nonlatch_clear: assert property (@(posedge mclk) disable iff (reset)
        clk_en && alarm_nonlatching_select && src_done[0] && !out_of_range[0]
        |=> !alarm_status[0])
        else $error("nonlatching alarm kept");
    a_reset_clears: assert property (@(posedge mclk)
        reset |=> alarm_status == '0)
        else $error("reset left alarm set");
endmodule : mdsr_bank

/* mdsr_pkg.sv */
// constants for the monitor data and status register bank
// assumes byte-wide register access over an 8-bit address port
package mdsr_pkg;
    // register map
    localparam logic [7:0] ADDR_RANGE_CD = 8'h1f;    // group c/d range select
    localparam logic [7:0] ADDR_ADC_FIRST = 8'h20;   // first channel result low byte
    localparam logic [7:0] ADDR_ADC_LAST = 8'h49;    // last channel result high byte
    localparam logic [7:0] ADDR_TEMP_LOW = 8'h4a;    // temperature low byte
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h4b;   // temperature high byte
    localparam logic [7:0] ADDR_DAC_FIRST = 8'h50;   // first output code low byte
    localparam logic [7:0] ADDR_DAC_LAST = 8'h6f;    // last output code high byte
    localparam logic [7:0] ADDR_STATUS0 = 8'h70;     // alarm status, channels 16..20
    localparam logic [7:0] ADDR_STATUS1 = 8'h71;     // alarm status, temperature group
    // sizes
    localparam int ADC_CHANNELS = 21;
    localparam int DAC_CHANNELS = 16;
    localparam int ALARM_COUNT = 9;                   // 5 channel + 4 temperature group
    localparam int STATUS0_BITS = 5;
    localparam int STATUS1_BITS = 4;
    localparam int FILTER_W = 3;                      // width of consecutive counter
    // range field layout
    localparam int RANGE_C_LSB = 0;
    localparam int RANGE_D_LSB = 4;
    localparam logic [7:0] RANGE_CD_MASK = 8'h77;     // reserved bits read zero
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // range field encoding
    typedef enum logic [2:0]
    {
        RNG_NEG10 = 3'h4,
        RNG_NEG5 = 3'h5,
        RNG_POS10 = 3'h6,
        RNG_POS5 = 3'h7
    } mdsr_range_t;
endpackage : mdsr_pkg

/* mdsr_alarm_bit.sv */
// one alarm status bit with n-consecutive filtering and read clearing
// assumes conv_done pulses once per conversion cycle, same clock
`timescale 1ns/1ps
module mdsr_alarm_bit
    import mdsr_pkg::*;
(
    // clocking
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // controls
    input wire logic conv_done,                 // one conversion result ready
    input wire logic out_of_range,              // comparison for this result
    input wire logic [FILTER_W-1:0] filter_n,   // consecutive count required
    input wire logic nonlatching,               // latch disable
    input wire logic status_read,               // status register read
    // state
    output logic alarm,                         // status bit
    output logic condition                      // filtered condition active
);
    logic [FILTER_W-1:0] run_count;             // consecutive out-of-range results
    wire reached = (run_count + 1'b1) >= filter_n;
    wire next_condition = conv_done ? (out_of_range && reached) : condition;
    wire set_now = conv_done && out_of_range && reached;

    // consecutive counter restarts on any in-range result
    always_ff @(posedge mclk)
    begin
        if (reset)
            run_count <= '0;
        else if (clk_en && conv_done)
            run_count <= !out_of_range ? '0 : (reached ? run_count : run_count + 1'b1);
    end

    // condition tracks filtered state, alarm holds until resolved and read, or only until resolved when nonlatching
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            condition <= 1'b0;
            alarm <= 1'b0;
        end
        else if (clk_en)
        begin
            condition <= next_condition;
            if (set_now)
                alarm <= 1'b1;                  // set wins over read clear
            else if (nonlatching && !next_condition)
                alarm <= 1'b0;
            else if (status_read && !condition)
                alarm <= 1'b0;
        end
    end
endmodule : mdsr_alarm_bit

/* mdsr_code_mem.sv */
// output code storage, one 12-bit code per channel, registered read
// assumes single-cycle byte writes from the register bank
`timescale 1ns/1ps
module mdsr_code_mem
    import mdsr_pkg::*;
(
    // clocking
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // byte write
    input wire logic wr_en,
    input wire logic [3:0] wr_chan,
    input wire logic wr_high,                   // high byte lane
    input wire logic [7:0] wr_data,
    // byte read
    input wire logic [3:0] rd_chan,
    input wire logic rd_high,
    output logic [7:0] rd_data,
    // full code of written channel for the latch
    output logic [11:0] latch_code
);
    logic [11:0] codes [DAC_CHANNELS];          // stored codes
    wire [11:0] old_code = codes[wr_chan];
    wire [11:0] next_code = wr_high ? {wr_data[3:0], old_code[7:0]}
                                    : {old_code[11:8], wr_data};

    // byte writes merge into stored code
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int i = 0; i < DAC_CHANNELS; i++)
                codes[i] <= '0;
            rd_data <= RESET_BYTE;
            latch_code <= '0;
        end
        else if (clk_en)
        begin
            if (wr_en)
            begin
                codes[wr_chan] <= next_code;
                latch_code <= next_code;
            end
            rd_data <= rd_high ? {4'h0, codes[rd_chan][11:8]} : codes[rd_chan][7:0];
        end
    end
endmodule : mdsr_code_mem

/* mdsr_host_model.sv */
// host side model: issues byte reads and writes on the bank access port
// assumes rd_valid pulses one cycle after the read strobe is taken
`timescale 1ns/1ps
module mdsr_host_model (
    // clocking
    input wire logic mclk,
    // access port toward the bank
    output logic [7:0] addr,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    ////////////////////////////////////////////////////////////////////
    // idle values at time zero
    initial
    begin
        addr = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_data = 8'h00;
    end

    // one-cycle write strobe; released lines show the inverse, never a stale value
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask : write_byte

    // one-cycle read strobe; answer taken at the edge on which rd_valid stands
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        ok = rd_valid;
        d = rd_data;
    endtask : read_byte
endmodule : mdsr_host_model

/* tb.sv */
// self-checking bench for the monitor data and status register bank
// assumes the host model in its own file and the design package
`timescale 1ns/1ps
module tb;
    import mdsr_pkg::*;
    // clock, reset and design inputs
    logic mclk, reset, clk_en, conv_done, alarm_nonlatching_select;
    logic [4:0] conv_chan;
    logic [11:0] conv_result;
    logic [ALARM_COUNT-1:0] out_of_range, alarm_source_clear;
    logic [FILTER_W-1:0] filter_n;
    // access port and design outputs
    logic [7:0] addr, wr_data, rd_data, rd;
    logic wr_en, rd_en, rd_valid, ok, c_auto, d_auto, dac_load, pin;
    logic [2:0] c_sel, d_sel;
    logic [3:0] load_chan;
    logic [11:0] output_code;
    logic [ALARM_COUNT-1:0] alarm_status;
    int miscompares, comparisons, cycles;

    ////////////////////////////////////////////////////////////////////
    mdsr_bank mdsr_bank_i (.mclk(mclk), .reset(reset), .clk_en(clk_en), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .conv_done(conv_done), .conv_chan(conv_chan),
        .conv_result(conv_result), .out_of_range(out_of_range), .filter_n(filter_n),
        .alarm_nonlatching_select(alarm_nonlatching_select),
        .alarm_source_clear(alarm_source_clear), .group_c_range_select(c_sel),
        .group_c_auto(c_auto), .group_d_range_select(d_sel), .group_d_auto(d_auto),
        .dac_load(dac_load), .dac_load_chan(load_chan), .output_code(output_code),
        .alarm_output_pin(pin), .alarm_status(alarm_status));
    mdsr_host_model mdsr_host_model_i (.mclk(mclk), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

    // clock, 10 ns period
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // hang guard: ceiling well above the roughly 180 cycles the tests need
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare one value and count it
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // read one byte and compare it, valid pulse included
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        mdsr_host_model_i.read_byte(a, rd, ok);
        check("rd_valid", 16'(ok), 16'h0001);
        check($sformatf("byte at %h", a), 16'(rd), 16'(exp));
    endtask : rd_chk

    // one conversion result, then settle
    task automatic conv(input logic [4:0] c, input logic [11:0] r, input logic [8:0] o);
        @(posedge mclk);
        conv_done <= 1'b1;
        conv_chan <= c;
        conv_result <= r;
        out_of_range <= o;
        @(posedge mclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : conv

    // reset held for two cycles
    task automatic do_reset();
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
    endtask : do_reset

    // counts, verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [7:0] w;
        reset = 1'b1;
        clk_en = 1'b1;
        conv_done = 1'b0;
        conv_chan = 5'h00;
        conv_result = 12'h000;
        out_of_range = '0;
        alarm_source_clear = '0;
        alarm_nonlatching_select = 1'b0;
        filter_n = 3'h3;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        // reset values and an unmapped place
        rd_chk(ADDR_RANGE_CD, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(ADDR_TEMP_HIGH, 8'h00);
        rd_chk(ADDR_DAC_LAST, 8'h00);
        rd_chk(8'h80, 8'h00);
        // every range code in both groups, reserved bits read zero
        for (int k = 0; k < 8; k++)
        begin
            w = {1'b1, 3'(k), 1'b1, 3'(7 - k)};
            mdsr_host_model_i.write_byte(ADDR_RANGE_CD, w);
            rd_chk(ADDR_RANGE_CD, w & RANGE_CD_MASK);
            check("group_d_range", 16'(d_sel), 16'(k));
            check("group_c_range", 16'(c_sel), 16'(7 - k));
            check("group_d_auto", 16'(d_auto), 16'(k < 4));
            check("group_c_auto", 16'(c_auto), 16'(k > 3));
        end
        // conversion results: first and last channel, temperature
        conv(5'h00, 12'habc, 9'h000);
        conv(5'h14, 12'hfff, 9'h000);
        conv(5'h15, 12'h9c4, 9'h000);
        mdsr_host_model_i.write_byte(ADDR_ADC_FIRST, 8'h55);
        rd_chk(ADDR_ADC_FIRST, 8'hbc);
        rd_chk(8'h21, 8'h0a);
        rd_chk(8'h48, 8'hff);
        rd_chk(ADDR_ADC_LAST, 8'h0f);
        rd_chk(ADDR_TEMP_LOW, 8'hc4);
        rd_chk(ADDR_TEMP_HIGH, 8'h09);
        // output codes: low then high byte, the high byte write loads the merged code
        mdsr_host_model_i.write_byte(ADDR_DAC_FIRST, 8'h34);
        mdsr_host_model_i.write_byte(8'h51, 8'h0c);
        @(negedge mclk);
        check("dac_load", 16'(dac_load), 16'h0001);
        check("dac_load_chan", 16'(load_chan), 16'h0000);
        check("output_code", 16'(output_code), 16'h0c34);
        mdsr_host_model_i.write_byte(ADDR_DAC_LAST, 8'h0f);
        @(negedge mclk);
        check("dac_load_chan", 16'(load_chan), 16'h000f);
        rd_chk(ADDR_DAC_FIRST, 8'h34);
        rd_chk(ADDR_DAC_LAST, 8'h0f);
        // filter: two bad, one good, two bad leaves the bit clear
        for (int k = 0; k < 5; k++)
            conv(5'h10, 12'h000, (k == 2) ? 9'h000 : 9'h001);
        check("status filtered", 16'(alarm_status), 16'h0000);
        conv(5'h10, 12'h000, 9'h001);
        check("status set", 16'(alarm_status), 16'h0001);
        check("pin set", 16'(pin), 16'h0001);
        alarm_source_clear <= 9'h001;
        repeat (3) @(posedge mclk);
        check("pin masked", 16'(pin), 16'h0000);
        alarm_source_clear <= 9'h000;
        rd_chk(ADDR_STATUS0, 8'h01);
        check("status held", 16'(alarm_status), 16'h0001);
        conv(5'h10, 12'h000, 9'h000);
        check("status unread", 16'(alarm_status), 16'h0001);
        rd_chk(ADDR_STATUS0, 8'h01);
        filter_n <= 3'h1;
        @(negedge mclk);
        check("status cleared", 16'(alarm_status), 16'h0000);
        check("pin cleared", 16'(pin), 16'h0000);
        // temperature group through its own status byte
        conv(5'h15, 12'h000, 9'h020);
        conv(5'h15, 12'h000, 9'h000);
        rd_chk(ADDR_STATUS1, 8'h01);
        // non-latching: clears on the first good result, unread
        alarm_nonlatching_select <= 1'b1;
        conv(5'h11, 12'h000, 9'h002);
        check("nonlatch set", 16'(alarm_status), 16'h0002);
        conv(5'h11, 12'h000, 9'h000);
        check("nonlatch clear", 16'(alarm_status), 16'h0000);
        // reset in mid-run clears a standing alarm
        alarm_nonlatching_select <= 1'b0;
        conv(5'h12, 12'h000, 9'h004);
        check("status before reset", 16'(alarm_status), 16'h0004);
        do_reset();
        @(negedge mclk);
        check("status after reset", 16'(alarm_status), 16'h0000);
        rd_chk(ADDR_STATUS0, 8'h00);
        end_of_test();
    end
endmodule : tb
